/* File: pkg/acr_pkg.sv */
// Constants, types and helpers shared by the converter serial readout block.
// What this block does
// [R1] Select input is active low; low addresses the converter, high means idle.
// [R2] Every falling edge of select starts exactly one new conversion.
// [R3] Result bits move only while select stays low; select low frames one transfer.
// [R4] Serial result output changes on each serial clock falling edge, next frame bit.
// [R5] Frame is four zero bits then twelve result bits, sixteen in all.
// [R6] Result bits leave most significant first, least significant last.
// [R7] Result is twos complement; negative inputs give codes with top bit one.
// [R8] The serial clock alone paces the successive-approximation steps.
// [R9] Zero input sits between code all ones and code all zeros.
// [R10] Most positive code is a zero followed by all ones.
// [R11] Most negative code is a one followed by all zeros.
// [R12] Serial result output floats while select is high; drives only after select falls.
// [R13] Controller leaves at least the quiet time before the next select fall.
// [R14] Controller gives at least sixteen serial clocks per frame.
package acr_pkg;

   // Widths and frame layout.
   localparam int          RES_W      = 12;
   localparam int          CNT_W      = 5;
   localparam logic [4:0]  FRAME_LEN  = 5'h10;
   localparam logic [4:0]  LEAD_ZEROS = 5'h04;
   localparam logic [4:0]  SAR_STEPS  = 5'h0C;
   localparam logic [4:0]  FALL_RST   = 5'h00;
   localparam logic [3:0]  MSB_POS    = 4'hB;

   // Code values and reset values.
   localparam logic [11:0] MIDSCALE   = 12'h0800;
   localparam logic [11:0] RESULT_RST = 12'h0000;

   // Timing; the quiet time is kept by the controller, not enforced here.
   localparam int          MCLK_PERIOD_NS = 50;
   localparam int          QUIET_NS       = 60;
   localparam int          QUIET_CYC      = (QUIET_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   // Frame sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FRAME = 3'b010,
      ST_DONE  = 3'b100
   } acr_state_e;

   // Serial output pin: value and output enable travel together.
   typedef struct packed {
      logic drive;
      logic bit_out;
   } acr_pin_s;

   // Bit shown on the serial output after a given number of clock falls.
   function automatic logic frame_bit(input logic [11:0] res, input logic [4:0] idx);
      logic [4:0] pos;
      pos = 5'h0F - idx;
      if (idx < LEAD_ZEROS) begin
         frame_bit = 1'b0;
      end else begin
         frame_bit = res[pos[3:0]];
      end
   endfunction

endpackage

/* File: hw/acr_sync.sv */
// Two-flop synchroniser for the select and serial clock pins.
`timescale 1ns/1ps
module acr_sync (
   // Clock and reset.
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   // Asynchronous pins in, settled levels out.
   input  wire logic [1:0] i_async,
   output logic      [1:0] o_sync
);

   logic [1:0] meta_reg;

   // Pins idle high, so both stages reset high to avoid a false edge.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= 2'h3;
         o_sync   <= 2'h3;
      end else begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end

endmodule // acr_sync

/* File: hw/acr_sar.sv */
// Successive-approximation register stepped once per serial clock fall.
`timescale 1ns/1ps
module acr_sar (
   // Clock and reset.
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Control from the frame sequencer.
   input  wire logic        i_start,
   input  wire logic        i_step,
   // Comparator: high when the held input is above the trial level.
   input  wire logic        i_cmp_gt,
   // Trial code to the DAC, result so far and completion pulse.
   output logic      [11:0] o_dac_code,
   output logic      [11:0] o_result,
   output logic             o_done
);

   logic [11:0] trial_reg;
   logic [3:0]  pos_reg;
   logic        busy_reg;

   // One bit is decided per step, so conversion speed follows the serial clock.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         trial_reg <= acr_pkg::RESULT_RST;
         pos_reg   <= acr_pkg::MSB_POS;
         busy_reg  <= 1'b0;
         o_done    <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            trial_reg <= acr_pkg::MIDSCALE;
            pos_reg   <= acr_pkg::MSB_POS;
            busy_reg  <= 1'b1;
         end else if (i_step && busy_reg) begin // see [R8]
            trial_reg[pos_reg] <= i_cmp_gt;
            if (pos_reg != 4'h0) begin
               trial_reg[pos_reg - 4'h1] <= 1'b1;
               pos_reg                   <= pos_reg - 4'h1;
            end else begin
               busy_reg <= 1'b0;
               o_done   <= 1'b1;
            end
         end
      end
   end

   // Offset binary to twos complement: midscale becomes zero, ends become 7FF and 800.
   assign o_dac_code = trial_reg;
   assign o_result   = {~trial_reg[11], trial_reg[10:0]}; // see [R7] see [R9] see [R10] see [R11]

endmodule // acr_sar

/* File: hw/acr_readout.sv */
// Top of the converter: select-framed conversion start and serial result readout.
`timescale 1ns/1ps
module acr_readout (
   // Clock and reset.
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Serial link pins from the controller.
   input  wire logic        i_cs_n,
   input  wire logic        i_sclk,
   // Serial result pin, value and output enable.
   output logic             o_serial_result_out,
   output logic             o_serial_result_out_oe,
   // Analog front end: comparator in, trial code and track control out.
   input  wire logic        i_cmp_gt,
   output logic      [11:0] o_dac_code,
   output logic             o_track,
   // Last completed conversion, twos complement.
   output logic      [11:0] o_result
);

   logic [1:0]         sync_w;
   logic               cs_n_s;
   logic               sclk_s;
   logic               cs_n_q_reg;
   logic               sclk_q_reg;
   logic               cs_fall;
   logic               cs_rise;
   logic               sclk_fall;
   acr_pkg::acr_state_e state_reg;
   acr_pkg::acr_state_e state_next;
   logic [4:0]         falls_reg;
   logic [4:0]         falls_inc;
   acr_pkg::acr_pin_s  pin_reg;
   logic               sar_start;
   logic               sar_step;
   logic               sar_done;
   logic [11:0]        sar_result;
   logic               track_reg;
   logic [11:0]        result_reg;

   // Both pins come from the controller's domain and are settled first.
   acr_sync u_sync (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_async ({i_cs_n, i_sclk}),
      .o_sync  (sync_w)
   );

   assign cs_n_s = sync_w[1];
   assign sclk_s = sync_w[0];

   // Delayed copies of the settled levels give the edge detectors.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_n_q_reg <= 1'b1;
         sclk_q_reg <= 1'b1;
      end else begin
         cs_n_q_reg <= cs_n_s;
         sclk_q_reg <= sclk_s;
      end
   end

   assign cs_fall   = cs_n_q_reg & ~cs_n_s; // see [R1]
   assign cs_rise   = ~cs_n_q_reg & cs_n_s;
   assign sclk_fall = sclk_q_reg & ~sclk_s;
   assign falls_inc = falls_reg + 5'h01;

   // Sequencer: select low opens a frame, select high always closes it.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         acr_pkg::ST_IDLE: begin
            if (cs_fall) begin
               state_next = acr_pkg::ST_FRAME; // see [R2]
            end
         end
         acr_pkg::ST_FRAME: begin
            if (cs_n_s) begin
               state_next = acr_pkg::ST_IDLE; // see [R3]
            end else if (sclk_fall && falls_inc == acr_pkg::FRAME_LEN) begin
               state_next = acr_pkg::ST_DONE;
            end
         end
         acr_pkg::ST_DONE: begin
            if (cs_n_s) begin
               state_next = acr_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = acr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= acr_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Count serial clock falls inside the frame; extra clocks after sixteen are ignored.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         falls_reg <= acr_pkg::FALL_RST;
      end else if (state_reg == acr_pkg::ST_IDLE) begin
         falls_reg <= acr_pkg::FALL_RST;
      end else if (state_reg == acr_pkg::ST_FRAME && !cs_n_s && sclk_fall) begin
         falls_reg <= falls_inc; // see [R3]
      end
   end

   // Conversion starts with the frame and steps on the first twelve clock falls.
   assign sar_start = (state_reg == acr_pkg::ST_IDLE) && cs_fall; // see [R2]
   assign sar_step  = (state_reg == acr_pkg::ST_FRAME) && !cs_n_s && sclk_fall
                      && (falls_reg < acr_pkg::SAR_STEPS); // see [R8]

   acr_sar u_sar (
      .i_mclk     (i_mclk),
      .i_rst_n    (i_rst_n),
      .i_start    (sar_start),
      .i_step     (sar_step),
      .i_cmp_gt   (i_cmp_gt),
      .o_dac_code (o_dac_code),
      .o_result   (sar_result),
      .o_done     (sar_done)
   );

   // The serial output drives the first leading zero as soon as the frame opens.
   // Each result bit is decided three clock falls before it is shown, so no stall.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_reg <= '0;
      end else if (state_reg == acr_pkg::ST_IDLE) begin
         if (cs_fall) begin
            pin_reg.drive   <= 1'b1; // see [R12]
            pin_reg.bit_out <= 1'b0; // see [R5]
         end
      end else if (cs_n_s) begin
         pin_reg <= '0; // see [R12]
      end else if (state_reg == acr_pkg::ST_FRAME && sclk_fall) begin
         if (falls_inc == acr_pkg::FRAME_LEN) begin
            pin_reg <= '0;
         end else begin
            pin_reg.bit_out <= acr_pkg::frame_bit(sar_result, falls_inc); // see [R4] see [R6]
         end
      end
   end

   assign o_serial_result_out    = pin_reg.bit_out;
   assign o_serial_result_out_oe = pin_reg.drive;

   // Hold the input from the select fall until the last decision, then track again.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         track_reg <= 1'b1;
      end else if (sar_start) begin
         track_reg <= 1'b0;
      end else if (sar_done || state_reg == acr_pkg::ST_IDLE) begin
         track_reg <= 1'b1;
      end
   end

   assign o_track = track_reg;

   // A frame cut short before its twelfth clock fall leaves the previous result in place.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         result_reg <= acr_pkg::RESULT_RST;
      end else if (sar_done) begin
         result_reg <= sar_result; // see [R7]
      end
   end

   assign o_result = result_reg;

   // Checks on the frame, the output pin and the conversion.
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   property p_start;
      (state_reg == acr_pkg::ST_IDLE) && cs_fall |=> (state_reg == acr_pkg::ST_FRAME)
         && o_serial_result_out_oe && !o_track && (falls_reg == acr_pkg::FALL_RST);
   endproperty
   a_start: assert property (p_start) else $error("select fall did not open a frame"); // see [R2]

   property p_float;
      cs_n_s && cs_n_q_reg |-> !o_serial_result_out_oe;
   endproperty
   a_float: assert property (p_float) else $error("output driven while select high"); // see [R12]

   property p_lead;
      o_serial_result_out_oe && (falls_reg < acr_pkg::LEAD_ZEROS) |-> !o_serial_result_out;
   endproperty
   a_lead: assert property (p_lead) else $error("leading bit not zero"); // see [R5]

   property p_shift;
      (state_reg == acr_pkg::ST_FRAME) && !cs_n_s && sclk_fall
         && (falls_inc != acr_pkg::FRAME_LEN) |=>
         (falls_reg == $past(falls_inc))
         && (o_serial_result_out == acr_pkg::frame_bit($past(sar_result), falls_reg));
   endproperty
   a_shift: assert property (p_shift) else $error("output not updated on clock fall"); // see [R4]

   property p_hold;
      o_serial_result_out_oe && !sclk_fall && !cs_n_s |=> $stable(o_serial_result_out);
   endproperty
   a_hold: assert property (p_hold) else $error("output changed without clock fall"); // see [R4]

   property p_msb;
      o_serial_result_out_oe && (falls_reg == acr_pkg::LEAD_ZEROS)
         |-> (o_serial_result_out == sar_result[11]);
   endproperty
   a_msb: assert property (p_msb) else $error("MSB not first after zeros"); // see [R6]

   property p_end;
      (state_reg == acr_pkg::ST_FRAME) && !cs_n_s && sclk_fall
         && (falls_inc == acr_pkg::FRAME_LEN) |=> !o_serial_result_out_oe ##1 !o_serial_result_out_oe;
   endproperty
   a_end: assert property (p_end) else $error("output still driven after sixteen bits"); // see [R5]

   property p_twos;
      sar_done |=> (result_reg == {~o_dac_code[11], o_dac_code[10:0]}) && o_track;
   endproperty
   a_twos: assert property (p_twos) else $error("result not twos complement"); // see [R7]

   property p_step;
      sar_step && (falls_reg == 5'h0B) |=> sar_done;
   endproperty
   a_step: assert property (p_step) else $error("twelfth clock fall did not finish"); // see [R8]

   // A fresh conversion always begins from the midscale trial code.
   property p_dac_start;
      sar_start |=> (o_dac_code == acr_pkg::MIDSCALE);
   endproperty
   a_dac_start: assert property (p_dac_start) else $error("trial code not midscale"); // see [R8]

   // Select rising closes any open frame and releases the pin on the next edge.
   property p_abort;
      cs_rise && (state_reg != acr_pkg::ST_IDLE) |=> (state_reg == acr_pkg::ST_IDLE)
         && !o_serial_result_out_oe;
   endproperty
   a_abort: assert property (p_abort) else $error("select rise did not end frame"); // see [R3]

   // Serial clocks while select is high must neither count nor drive the pin.
   property p_idle_sclk;
      (state_reg == acr_pkg::ST_IDLE) && sclk_fall && !cs_fall |=>
         (falls_reg == acr_pkg::FALL_RST) && !o_serial_result_out_oe;
   endproperty
   a_idle_sclk: assert property (p_idle_sclk) else $error("clock counted outside frame"); // see [R3]

   // Once sixteen bits are out the pin stays released until select rises.
   property p_done_quiet;
      (state_reg == acr_pkg::ST_DONE) |-> !o_serial_result_out_oe;
   endproperty
   a_done_quiet: assert property (p_done_quiet) else $error("pin driven after frame end"); // see [R5]

   // A midscale final trial is the zero input, which reads as code zero.
   property p_zero;
      sar_done && (o_dac_code == acr_pkg::MIDSCALE) |=> (result_reg == 12'h000);
   endproperty
   a_zero: assert property (p_zero) else $error("zero input not code zero"); // see [R9]

   // The top trial code is the most positive twos complement value.
   property p_top;
      sar_done && (o_dac_code == 12'hFFF) |=> (result_reg == 12'h7FF);
   endproperty
   a_top: assert property (p_top) else $error("top code not most positive"); // see [R10]

   // The bottom trial code is the most negative twos complement value.
   property p_bottom;
      sar_done && (o_dac_code == 12'h000) |=> (result_reg == 12'h800);
   endproperty
   a_bottom: assert property (p_bottom) else $error("bottom code not most negative"); // see [R11]

   // Covers: whole frames, cut frames, both signs and clocks beyond sixteen.

   c_full: cover property ((state_reg == acr_pkg::ST_FRAME) ##1 (state_reg == acr_pkg::ST_DONE));
   c_abort: cover property ((state_reg == acr_pkg::ST_FRAME) && cs_n_s && (falls_reg < 5'h08));
   c_neg: cover property (sar_done ##1 result_reg[11]);
   c_pos: cover property (sar_done ##1 !result_reg[11]);
   c_extra: cover property ((state_reg == acr_pkg::ST_DONE) && sclk_fall);

endmodule // acr_readout

/* File: sim/acr_ctrl_model.sv */
// Behavioural serial controller that frames conversions and collects result words.
`timescale 1ns/1ps
module acr_ctrl_model (
   // System clock used only to pace the link.
   input  wire logic i_mclk,
   // Link pins.
   output logic      o_cs_n,
   output logic      o_sclk,
   input  wire logic i_line,
   input  wire logic i_oe
);

   // Select idles high and the serial clock stands still high between frames.
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b1;
   end

   // Waits n system clocks, then steps off the edge by the fixed drive delay.
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_mclk);
      #2;
   endtask

   // One serial clock period of 400 ns; both phases are four system clocks.
   task automatic one_clock();
      o_sclk = 1'b0;
      wait_clk(4);
      o_sclk = 1'b1;
      wait_clk(4);
   endtask

   // Serial clocks with select high; the converter must ignore them.
   task automatic idle_clocks(input int n);
      for (int k = 0; k < n; k++) begin
         one_clock();
      end
   endtask

   // Frame with nfalls clocks; a bit is sampled just before the fall that replaces it.
   // Fewer than sixteen falls is an abort on purpose, more tests that extras are ignored.
   task automatic run_frame(input int nfalls, output logic [15:0] word,
                            output logic [15:0] oe_seen);
      word    = 16'h0000;
      oe_seen = 16'h0000;
      wait_clk(1);
      o_cs_n = 1'b0;
      wait_clk(8);
      for (int k = 0; k < nfalls; k++) begin
         if (k < 16) begin
            word[15-k]    = i_line;
            oe_seen[15-k] = i_oe;
         end
         one_clock();
      end
      o_cs_n = 1'b1;
      wait_clk(2);
   endtask

endmodule // acr_ctrl_model

/* File: sim/tb_acr_readout.sv */
// Self-checking testbench for the converter's select-framed serial readout.
`timescale 1ns/1ps
module tb_acr_readout;

   logic        i_mclk;
   logic        i_rst_n;
   logic        i_cs_n;
   logic        i_sclk;
   logic        i_cmp_gt;
   logic        o_serial_result_out;
   logic        o_serial_result_out_oe;
   logic        o_track;
   logic [11:0] o_dac_code;
   logic [11:0] o_result;
   logic        serial_result_out_line;
   logic        last_bit;
   logic [11:0] ain_code;
   logic [15:0] word;
   logic [15:0] oe_seen;
   int          n_mismatch;
   int          cmp_count;

   // Held input sits half a step above its code, so > or >= in the SAR gives one answer.
   assign i_cmp_gt = ({ain_code ^ acr_pkg::MIDSCALE, 1'b1} > {o_dac_code, 1'b0});

   // A released line shows the inverse of its last value, never a friendly copy.
   always @(posedge i_mclk) begin
      if (o_serial_result_out_oe) begin
         last_bit <= o_serial_result_out;
      end
   end
   assign serial_result_out_line = o_serial_result_out_oe ? o_serial_result_out : ~last_bit;

   acr_readout uut (
      .i_mclk                 (i_mclk),
      .i_rst_n                (i_rst_n),
      .i_cs_n                 (i_cs_n),
      .i_sclk                 (i_sclk),
      .o_serial_result_out    (o_serial_result_out),
      .o_serial_result_out_oe (o_serial_result_out_oe),
      .i_cmp_gt               (i_cmp_gt),
      .o_dac_code             (o_dac_code),
      .o_track                (o_track),
      .o_result               (o_result)
   );

   acr_ctrl_model u_ctrl (
      .i_mclk (i_mclk),
      .o_cs_n (i_cs_n),
      .o_sclk (i_sclk),
      .i_line (serial_result_out_line),
      .i_oe   (o_serial_result_out_oe)
   );

   // System clock of 50 ns.
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   // Counts every comparison and reports each mismatch on one line.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error: %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Outputs while reset is still held.
   task automatic t_reset();
      #2;
      check("oe in reset", o_serial_result_out_oe, 1'b0);
      check("track in reset", o_track, 1'b1);
      check("result in reset", o_result, acr_pkg::RESULT_RST);
      check("dac in reset", o_dac_code, 12'h0000);
   endtask

   // Serial clocks with select high must neither drive the pin nor convert.
   task automatic t_idle();
      u_ctrl.idle_clocks(3);
      check("oe idle", o_serial_result_out_oe, 1'b0);
      check("result idle", o_result, acr_pkg::RESULT_RST);
   endtask

   // Boundary and mid-range codes, frames back to back with a quiet gap of three system clocks.
   task automatic t_codes();
      logic [11:0] codes [6];
      codes = '{12'h07FF, 12'h0800, 12'h0FFF, 12'h0000, 12'h05A3, 12'h0A5C};
      foreach (codes[i]) begin
         ain_code = codes[i];
         u_ctrl.run_frame(16, word, oe_seen);
         check("frame word", word, {4'h0, codes[i]});
         check("oe per bit", oe_seen, 16'hFFFF);
         check("result", o_result, codes[i]);
      end
   endtask

   // Track drops at select fall and returns once twelve clocks finished the conversion.
   task automatic t_track();
      ain_code = 12'h03C5;
      fork
         u_ctrl.run_frame(16, word, oe_seen);
         begin
            repeat (10) @(posedge i_mclk);
            #2;
            check("track in conversion", o_track, 1'b0);
            repeat (93) @(posedge i_mclk);
            #2;
            check("track after twelve", o_track, 1'b1);
            check("result after twelve", o_result, 12'h03C5);
         end
      join
   endtask

   // Select rises mid-frame: pin released, old result kept, next fall converts again.
   task automatic t_abort();
      ain_code = 12'h0123;
      u_ctrl.run_frame(6, word, oe_seen);
      repeat (4) @(posedge i_mclk);
      #2;
      check("oe after abort", o_serial_result_out_oe, 1'b0);
      check("result after abort", o_result, 12'h03C5);
      check("track after abort", o_track, 1'b1);
      u_ctrl.run_frame(16, word, oe_seen);
      check("word after abort", word, 16'h0123);
   endtask

   // Clocks beyond sixteen leave the pin released.
   task automatic t_extra();
      ain_code = 12'h0E01;
      fork
         u_ctrl.run_frame(18, word, oe_seen);
         begin
            repeat (142) @(posedge i_mclk);
            #2;
            check("oe after sixteen", o_serial_result_out_oe, 1'b0);
         end
      join
      check("word with extras", word, 16'h0E01);
   endtask

   // Main sequence.
   initial begin
      i_rst_n    = 1'b0;
      last_bit   = 1'b0;
      ain_code   = 12'h0000;
      n_mismatch = 0;
      cmp_count  = 0;
      repeat (12) @(posedge i_mclk);
      t_reset();
      i_rst_n = 1'b1;
      t_idle();
      t_codes();
      t_track();
      t_abort();
      t_extra();
      end_sim();
   end

   // Watchdog well beyond the roughly 1400 clocks the scenarios need.
   initial begin
      #2000000;
      n_mismatch++;
      end_sim();
   end

endmodule // tb_acr_readout
